// [rtl/dasf_pkg.sv]
/*
 * Shared constants and types of the data addressing and status flag core.
 * Assumes a 12-bit data space and a 32-bit register bus with byte addresses.
 */
package dasf_pkg;

    // Operation codes decoded by the pipeline ahead of this block.
    typedef enum logic [3:0] {
        ALU_ADD   = 4'h0,
        ALU_SUB   = 4'h1,
        ALU_AND   = 4'h2,
        ALU_IOR   = 4'h3,
        ALU_XOR   = 4'h4,
        ALU_MOVE  = 4'h5,
        ALU_CLEAR = 4'h6,
        ALU_RLC   = 4'h7,
        ALU_RRC   = 4'h8,
        ALU_SWAP  = 4'h9,
        ALU_BCLR  = 4'ha,
        ALU_BSET  = 4'hb,
        ALU_STORE = 4'hc,
        ALU_JUMP  = 4'hd
    } dasf_op_e;

    // Flag positions inside the status register.
    localparam int FLAG_C   = 0;
    localparam int FLAG_NC  = 1;
    localparam int FLAG_Z   = 2;
    localparam int FLAG_OV  = 3;
    localparam int FLAG_NEG = 4;
    localparam int FLAG_W   = 5;

    // Data space map of the status register and indirect operands.
    localparam logic [11:0] STATUS_ADDR  = 12'hfd8;
    localparam logic [11:0] IND_BASE     = 12'hfef;
    localparam logic [11:0] IND_STRIDE   = 12'h008;
    localparam logic [11:0] OFS_PLAIN    = 12'h000;
    localparam logic [11:0] OFS_POST_INCREMENT_OPERAND  = 12'h001;
    localparam logic [11:0] OFS_POST_DECREMENT_OPERAND  = 12'h002;
    localparam logic [11:0] OFS_PRE_INCREMENT_OPERAND   = 12'h003;
    localparam logic [11:0] OFS_OFFSET_BY_ACCUMULATOR_OPERAND    = 12'h004;
    localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
    localparam logic [3:0]  ACCESS_HIGH  = 4'hf;
    localparam logic [3:0]  ACCESS_LOW   = 4'h0;
    localparam int          NUM_PTR      = 3;

    // Register bus byte offsets.
    localparam logic [7:0] REG_FLAGS  = 8'h00;
    localparam logic [7:0] REG_BANK   = 8'h04;
    localparam logic [7:0] REG_ACC    = 8'h08;
    localparam logic [7:0] REG_PTR0   = 8'h0c;
    localparam logic [7:0] REG_STRIDE = 8'h04;

endpackage

// [rtl/dasf_alu.sv]
/*
 * Combinational arithmetic unit: result, new flags and the mask of flags
 * that the operation affects. Assumes operands are already selected.
 */
`timescale 1ns/100ps
module dasf_alu (
    // Operation and operands.
    input  wire logic [3:0] i_op,
    input  wire logic [7:0] i_src,
    input  wire logic [7:0] i_acc,
    input  wire logic [2:0] i_bit,
    input  wire logic       i_carry,
    // Results.
    output logic [7:0]      o_result,
    output logic [4:0]      o_flags,
    output logic [4:0]      o_mask
);
    logic [7:0] addend;
    logic [8:0] sum;
    logic [4:0] nib;
    logic       arith;
    logic       rot;

    // Subtraction adds the inverted accumulator plus one.
    // borrow by complement
    assign addend = (i_op == dasf_pkg::ALU_SUB) ? ~i_acc : i_acc;
    assign arith  = (i_op == dasf_pkg::ALU_ADD) || (i_op == dasf_pkg::ALU_SUB);
    assign rot    = (i_op == dasf_pkg::ALU_RLC) || (i_op == dasf_pkg::ALU_RRC);
    assign sum    = {1'b0, i_src} + {1'b0, addend} + {8'h00, (i_op == dasf_pkg::ALU_SUB)};
    assign nib    = {1'b0, i_src[3:0]} + {1'b0, addend[3:0]}
                  + {4'h0, (i_op == dasf_pkg::ALU_SUB)};

    // Result selection per operation.
    always_comb begin
        case (i_op)
            dasf_pkg::ALU_ADD, dasf_pkg::ALU_SUB: o_result = sum[7:0];
            dasf_pkg::ALU_AND:   o_result = i_src & i_acc;
            dasf_pkg::ALU_IOR:   o_result = i_src | i_acc;
            dasf_pkg::ALU_XOR:   o_result = i_src ^ i_acc;
            dasf_pkg::ALU_CLEAR: o_result = 8'h00;
            dasf_pkg::ALU_RLC:   o_result = {i_src[6:0], i_carry};
            dasf_pkg::ALU_RRC:   o_result = {i_carry, i_src[7:1]};
            dasf_pkg::ALU_SWAP:  o_result = {i_src[3:0], i_src[7:4]};
            dasf_pkg::ALU_BCLR:  o_result = i_src & ~(8'h01 << i_bit);
            dasf_pkg::ALU_BSET:  o_result = i_src | (8'h01 << i_bit);
            dasf_pkg::ALU_STORE: o_result = i_acc;
            default:             o_result = i_src;
        endcase
    end

    // New flag values and which of them this operation owns.
    always_comb begin
        o_flags = 5'h00;
        o_mask  = 5'h00;
        o_flags[dasf_pkg::FLAG_NEG] = o_result[7];
        o_flags[dasf_pkg::FLAG_Z]   = (o_result == 8'h00);
        o_flags[dasf_pkg::FLAG_OV]  = (i_src[7] == addend[7]) && (sum[7] != i_src[7]);
        if (arith) begin
            o_flags[dasf_pkg::FLAG_NC] = nib[4];
            o_flags[dasf_pkg::FLAG_C]  = sum[8];
            o_mask = 5'h1f;
        end else if (rot) begin
            o_flags[dasf_pkg::FLAG_NC] = (i_op == dasf_pkg::ALU_RLC) ? i_src[3] : i_src[4];
            o_flags[dasf_pkg::FLAG_C]  = (i_op == dasf_pkg::ALU_RLC) ? i_src[7] : i_src[0];
            o_mask = 5'h17;
        end else if (i_op == dasf_pkg::ALU_CLEAR) begin
            o_mask = 5'h04;
        end else if (i_op <= dasf_pkg::ALU_MOVE) begin
            o_mask = 5'h14;
        end
    end
endmodule

// [rtl/dasf_core.sv]
/*
 * Data addressing and status flag core: forms data addresses, routes the
 * result and keeps the status, bank, accumulator and pointer registers.
 * Assumes the pipeline presents one operation per i_ex_valid pulse with
 * its source operand already read from data memory.
 */
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps

// How it works
// - Flag-affecting op aimed at status stores its flags, not its result.
// - Status bits 7 to 5 read zero and ignore writes.
// - Negative flag copies result bit 7.
// - Overflow flag set when signed result changes sign wrongly.
// - Zero flag set when result equals zero.
// - Add and subtract load nibble carry from bit 3 carry out.
// - Add and subtract load carry from bit 7 carry out.
// - Subtract adds the complement, so carries mean not-borrow.
// - Rotates load nibble carry from source bit 3 or bit 4.
// - Rotates load carry from source bit 7 or bit 0.
// - Literal ops take opcode operand; jumps carry a 20-bit target.
// - Banked direct address is bank register joined with 8-bit field.
// - Access direct address maps into the access bank.
// - Full 12-bit opcode address is used as is.
// - Destination bit one writes memory, zero writes accumulator; literal ops write accumulator, full-mode, bit and store ops memory.
// - Three 12-bit pointers built from low byte and high nibble.
// - Indirect operand addresses reach the location the pointer holds.
// - Indirect target ignores bank register and access bit.
// - Post modes step after access, pre-increment steps before.
// - Offset mode adds signed accumulator, changes nothing.
// - Pointer steps ripple over twelve bits and touch no flag.
module dasf_core (
    // Clock and reset.
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    // Operation from the pipeline.
    input  wire logic        i_ex_valid,
    input  wire logic [3:0]  i_ex_op,
    input  wire logic [7:0]  i_ex_file,
    input  wire logic        i_ex_access,
    input  wire logic        i_ex_dest,
    input  wire logic [2:0]  i_ex_bit,
    input  wire logic        i_ex_literal_mode,
    input  wire logic [7:0]  i_ex_literal,
    input  wire logic        i_ex_full_mode,
    input  wire logic [11:0] i_ex_full_addr,
    input  wire logic [19:0] i_ex_prog_addr,
    input  wire logic [7:0]  i_ex_operand,
    // Write-back toward data memory and program counter.
    output logic [11:0]      o_wb_addr,
    output logic [7:0]       o_wb_data,
    output logic             o_wb_mem_we,
    output logic [19:0]      o_pc_target,
    output logic             o_pc_load,
    output logic [7:0]       o_acc,
    output logic [7:0]       o_alu_flags,
    // Avalon-MM register slave.
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest
);
    localparam int NP = dasf_pkg::NUM_PTR;

    logic [4:0]  flags_q;
    logic [3:0]  bank_q;
    logic [7:0]  acc_q;
    logic [11:0] ptr_q   [NP];
    logic [11:0] ptr_d   [NP];
    logic [11:0] ind_tgt [NP];
    logic [NP-1:0] ind_hit;
    logic [11:0] raw_addr;
    logic [11:0] tgt_addr;
    logic [7:0]  src;
    logic [7:0]  result;
    logic [4:0]  new_flags;
    logic [4:0]  mask;
    logic        is_jump;
    logic        dest_mem;
    logic        hit_status;
    logic        acc_we;
    logic        ack_q;
    logic        bus_req;
    logic        bus_wr;

    // Direct address forming before any indirect substitution.
    always_comb begin
        if (i_ex_full_mode) begin
            raw_addr = i_ex_full_addr;
        end else if (i_ex_access) begin
            raw_addr = {bank_q, i_ex_file};
        end else if (i_ex_file >= dasf_pkg::ACCESS_SPLIT) begin
            raw_addr = {dasf_pkg::ACCESS_HIGH, i_ex_file};
        end else begin
            raw_addr = {dasf_pkg::ACCESS_LOW, i_ex_file};
        end
    end

    // Each pointer decodes its five operand addresses and its next value.
    generate
        for (genvar n = 0; n < NP; n++) begin : g_ptr
            localparam logic [11:0] BASE = dasf_pkg::IND_BASE
                                         - 12'(n * dasf_pkg::IND_STRIDE);
            logic [11:0] diff;
            assign diff = BASE - raw_addr;

            // Operand decode; stepping only where the mode asks for it.
            always_comb begin
                ind_hit[n] = 1'b1;
                ind_tgt[n] = ptr_q[n];
                ptr_d[n]   = ptr_q[n];
                case (diff)
                    dasf_pkg::OFS_PLAIN: ind_tgt[n] = ptr_q[n];
                    dasf_pkg::OFS_POST_INCREMENT_OPERAND: ptr_d[n] = ptr_q[n] + 12'h001;
                    dasf_pkg::OFS_POST_DECREMENT_OPERAND: ptr_d[n] = ptr_q[n] - 12'h001;
                    dasf_pkg::OFS_PRE_INCREMENT_OPERAND: begin
                        ind_tgt[n] = ptr_q[n] + 12'h001;
                        ptr_d[n]   = ptr_q[n] + 12'h001;
                    end
                    dasf_pkg::OFS_OFFSET_BY_ACCUMULATOR_OPERAND: ind_tgt[n] = ptr_q[n] + {{4{acc_q[7]}}, acc_q};
                    default: ind_hit[n] = 1'b0;
                endcase
            end

            // Pointer storage; bus writes yield to any operation addressing it, stepping or not.
            // twelve-bit pointer step
            always_ff @(posedge i_sys_clk) begin
                if (i_reset) begin
                    ptr_q[n] <= 12'h000;
                end else if (i_ex_valid && ind_hit[n] && !i_ex_literal_mode) begin
                    ptr_q[n] <= ptr_d[n];
                end else if (bus_wr && i_avs_address == dasf_pkg::REG_PTR0
                             + 8'(n * dasf_pkg::REG_STRIDE)) begin
                    if (i_avs_byteenable[0]) ptr_q[n][7:0] <= i_avs_writedata[7:0];
                    if (i_avs_byteenable[1]) ptr_q[n][11:8] <= i_avs_writedata[11:8];
                end
            end
        end
    endgenerate

    // Indirect operands replace the direct address with the pointer target.
    always_comb begin
        tgt_addr = raw_addr;
        for (int n = NP - 1; n >= 0; n--) begin
            if (ind_hit[n]) tgt_addr = ind_tgt[n];
        end
    end

    // Operand and destination selection.
    assign hit_status = (tgt_addr == dasf_pkg::STATUS_ADDR) && !i_ex_literal_mode;
    assign is_jump    = (i_ex_op == dasf_pkg::ALU_JUMP);
    assign src = i_ex_literal_mode ? i_ex_literal
               : hit_status ? {3'b000, flags_q} : i_ex_operand;
    assign dest_mem = !i_ex_literal_mode && !is_jump
                   && (i_ex_dest || i_ex_full_mode || i_ex_op >= dasf_pkg::ALU_BCLR);
    assign acc_we   = i_ex_valid && !dest_mem
                   && !is_jump;

    dasf_alu u_alu (
        .i_op     (i_ex_op),
        .i_src    (src),
        .i_acc    (acc_q),
        .i_bit    (i_ex_bit),
        .i_carry  (flags_q[dasf_pkg::FLAG_C]),
        .o_result (result),
        .o_flags  (new_flags),
        .o_mask   (mask)
    );

    // Status flags; an operation's own flags win over a bus write.
    // neutral ops hold flags unless stored to status
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            flags_q <= 5'h00;
        end else if (i_ex_valid && mask != 5'h00) begin
            flags_q <= (flags_q & ~mask) | (new_flags & mask);
        end else if (i_ex_valid && dest_mem && hit_status) begin
            flags_q <= result[4:0];
        end else if (bus_wr && i_avs_address == dasf_pkg::REG_FLAGS && i_avs_byteenable[0]) begin
            flags_q <= i_avs_writedata[4:0];
        end
    end

    // Accumulator and bank register.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            acc_q  <= 8'h00;
            bank_q <= 4'h0;
        end else begin
            if (acc_we) begin
                acc_q <= result;
            end else if (bus_wr && i_avs_address == dasf_pkg::REG_ACC && i_avs_byteenable[0]) begin
                acc_q <= i_avs_writedata[7:0];
            end
            if (bus_wr && i_avs_address == dasf_pkg::REG_BANK && i_avs_byteenable[0]) begin
                bank_q <= i_avs_writedata[3:0];
            end
        end
    end

    // Write-back stage. The status register lives here, so a result aimed
    // at it never reaches data memory.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_wb_addr   <= 12'h000;
            o_wb_data   <= 8'h00;
            o_wb_mem_we <= 1'b0;
            o_pc_target <= 20'h00000;
            o_pc_load   <= 1'b0;
        end else begin
            o_wb_mem_we <= i_ex_valid && dest_mem && !hit_status;
            o_pc_load   <= i_ex_valid && is_jump;
            if (i_ex_valid) begin
                o_wb_addr <= tgt_addr;
                o_wb_data <= result;
            end
            if (i_ex_valid && is_jump) begin
                o_pc_target <= i_ex_prog_addr;
            end
        end
    end

    assign o_acc       = acc_q;
    assign o_alu_flags = {3'b000, flags_q};

    // Bus slave: one wait cycle, then the answer. Taking one cycle keeps
    // read data registered at the cost of a slower bus.
    assign bus_req           = i_avs_read || i_avs_write;
    assign bus_wr            = i_avs_write && ack_q;
    assign o_avs_waitrequest = bus_req && !ack_q;

    // Acknowledge toggles low-high across each access.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req && !ack_q;
        end
    end

    // Read data captured during the wait cycle; unmapped reads give zero.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && !ack_q) begin
            o_avs_readdata <= 32'h0000_0000;
            case (i_avs_address)
                dasf_pkg::REG_FLAGS: o_avs_readdata[7:0] <= o_alu_flags;
                dasf_pkg::REG_BANK:  o_avs_readdata[3:0] <= bank_q;
                dasf_pkg::REG_ACC:   o_avs_readdata[7:0] <= acc_q;
                default: begin
                    for (int n = 0; n < NP; n++) begin
                        if (i_avs_address == dasf_pkg::REG_PTR0
                            + 8'(n * dasf_pkg::REG_STRIDE)) begin
                            o_avs_readdata[11:0] <= ptr_q[n];
                        end
                    end
                end
            endcase
        end
    end

    // Checks of the datapath against its contract.
    property p_status_dest;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_ex_valid && hit_status && mask != 5'h00)
            |=> !o_wb_mem_we && o_alu_flags[4:0] == (($past(flags_q) & ~$past(mask))
                                                  | ($past(new_flags) & $past(mask)));
    endproperty
    a_status_dest: assert property (p_status_dest) else $error("status dest wrote result");

    property p_upper_zero;
        @(posedge i_sys_clk) disable iff (i_reset)
        (bus_wr && i_avs_address == dasf_pkg::REG_FLAGS && i_avs_byteenable[0] && !i_ex_valid)
            |=> o_alu_flags == {3'b000, $past(i_avs_writedata[4:0])};
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("status upper bits set");

    property p_neg_zero;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_ex_valid && i_ex_op == dasf_pkg::ALU_AND && !hit_status)
            |=> o_alu_flags[4] == o_wb_data[7] && o_alu_flags[2] == (o_wb_data == 8'h00);
    endproperty
    a_neg_zero: assert property (p_neg_zero) else $error("neg or zero flag wrong");

    property p_add_carry;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_ex_valid && i_ex_op == dasf_pkg::ALU_ADD && !hit_status)
            |=> o_alu_flags[0] == (({1'b0, $past(src)} + {1'b0, $past(acc_q)}) > 9'h0ff);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

    property p_sub_borrow;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_ex_valid && i_ex_op == dasf_pkg::ALU_SUB && !hit_status)
            |=> o_alu_flags[0] == ($past(src) >= $past(acc_q));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("sub borrow wrong");

    property p_banked;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_ex_valid && i_ex_access && !i_ex_full_mode && bank_q != 4'hf)
            |=> o_wb_addr == {$past(bank_q), $past(i_ex_file)};
    endproperty
    a_banked: assert property (p_banked) else $error("banked address wrong");

    property p_dest_acc;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_ex_valid && !i_ex_dest && i_ex_op <= dasf_pkg::ALU_SWAP && !i_ex_full_mode)
            |=> !o_wb_mem_we && o_acc == o_wb_data;
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("result not in accumulator");

    property p_post_increment_operand;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_ex_valid && !i_ex_literal_mode && raw_addr == dasf_pkg::IND_BASE
         - dasf_pkg::OFS_POST_INCREMENT_OPERAND)
            |=> o_wb_addr == $past(ptr_q[0]) && ptr_q[0] == $past(ptr_q[0]) + 12'h001;
    endproperty
    a_post_increment_operand: assert property (p_post_increment_operand) else $error("post increment wrong");

    property p_neutral;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_ex_valid && i_ex_op == dasf_pkg::ALU_SWAP && !hit_status && !bus_wr)
            |=> $stable(o_alu_flags);
    endproperty
    a_neutral: assert property (p_neutral) else $error("neutral op moved flags");

    c_status_dest: cover property (@(posedge i_sys_clk) i_ex_valid && hit_status && mask != 5'h00);
    c_offset_by_accumulator_operand:       cover property (@(posedge i_sys_clk) i_ex_valid && ind_hit[0]
                                   && raw_addr == dasf_pkg::IND_BASE - dasf_pkg::OFS_OFFSET_BY_ACCUMULATOR_OPERAND);
    c_bus_read:    cover property (@(posedge i_sys_clk) i_avs_read && ack_q);
endmodule

// [tb/dasf_core_bench.sv]
/* Self-checking bench of the addressing and status flag core.
   Assumes a one-cycle execute answer and the two-cycle register bus of the core. */
`timescale 1ns/100ps
module dasf_core_bench;
    logic        clk, rst, ev, acs, dst, lm, fm, rd, wr;
    logic [3:0]  op, be;
    logic [2:0]  bn;
    logic [7:0]  fil, lit, opr, ad, acc, bank, r;
    logic [11:0] fa, ea;
    logic [19:0] pa;
    logic [31:0] wd, q;
    logic [4:0]  fl;
    logic [12:0] m;
    logic [11:0] wb_addr;
    logic [7:0]  wb_data, o_acc, flags;
    logic [19:0] pc_t;
    logic        wb_we, pc_ld, wreq;
    logic [31:0] rdata;
    int          errors, samples_checked, cyc, seed;
    dasf_core dasf_core_inst (.i_sys_clk(clk), .i_reset(rst), .i_ex_valid(ev), .i_ex_op(op),
        .i_ex_file(fil), .i_ex_access(acs), .i_ex_dest(dst), .i_ex_bit(bn),
        .i_ex_literal_mode(lm), .i_ex_literal(lit), .i_ex_full_mode(fm), .i_ex_full_addr(fa),
        .i_ex_prog_addr(pa), .i_ex_operand(opr), .o_wb_addr(wb_addr), .o_wb_data(wb_data),
        .o_wb_mem_we(wb_we), .o_pc_target(pc_t), .o_pc_load(pc_ld), .o_acc(o_acc),
        .o_alu_flags(flags), .i_avs_address(ad), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq));
    // Expected result and flags {N,OV,Z,NC,C}; subtract adds the complement.
    function automatic logic [12:0] model(input logic [3:0] o, input logic [7:0] s, a,
                                          input logic [4:0] f);
        logic [8:0] t;
        logic [4:0] h, r;
        logic [7:0] b, x;
        b = (o == dasf_pkg::ALU_SUB) ? ~a : a;
        t = s + b + (o == dasf_pkg::ALU_SUB);
        h = s[3:0] + b[3:0] + (o == dasf_pkg::ALU_SUB);
        x = t[7:0];
        r = f;
        // Flags an operation does not own keep their old value.
        case (o)
            dasf_pkg::ALU_AND:   x = s & a;
            dasf_pkg::ALU_IOR:   x = s | a;
            dasf_pkg::ALU_XOR:   x = s ^ a;
            dasf_pkg::ALU_MOVE:  x = s;
            dasf_pkg::ALU_CLEAR: x = 8'h00;
            dasf_pkg::ALU_RLC:   {r[1], r[0], x} = {s[3], s[7], s[6:0], f[0]};
            dasf_pkg::ALU_RRC:   {r[1], r[0], x} = {s[4], s[0], f[0], s[7:1]};
            dasf_pkg::ALU_SWAP:  x = {s[3:0], s[7:4]};
            default: {r[3], r[1], r[0]} = {(s[7] == b[7]) && (x[7] != s[7]), h[4], t[8]};
        endcase
        if (o != dasf_pkg::ALU_SWAP)
            r[2] = (x == 8'h00);
        if (o != dasf_pkg::ALU_SWAP && o != dasf_pkg::ALU_CLEAR)
            r[4] = x[7];
        return {x, r};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus cycle: hold the request until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        ad <= a;
        wd <= d;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic ex(input logic [3:0] o, input logic f, input logic [11:0] a,
                      input logic [7:0] d, input logic ds);
        @(posedge clk);
        ev <= 1'b1;
        op <= o;
        fm <= f;
        fa <= a;
        opr <= d;
        dst <= ds;
        @(posedge clk);
        ev <= 1'b0;
        #1;
    endtask
    task automatic test_done();
        $display("errors %0d checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // A hang is cut short well past the expected run length.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        {rst, ev, acs, dst, lm, fm, rd, wr, op, bn, fil, lit, opr, ad, fa, pa, wd} = '0;
        be = 4'h1;
        seed = 40867;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        bus(0, dasf_pkg::REG_FLAGS, 0);
        chk(q, 0);
        bus(0, 8'hfc, 0);
        chk(q, 0);
        bus(1, dasf_pkg::REG_FLAGS, 32'hff);
        bus(0, dasf_pkg::REG_FLAGS, 0);
        chk(q, 32'h1f);
        fl = 5'h1f;
        // Random ops from add through swap over banked and access addressing.
        for (int i = 0; i < 40; i++) begin
            acc = (i == 0) ? 8'h01 : $random(seed);
            bank = $random(seed);
            bus(1, dasf_pkg::REG_ACC, acc);
            bus(1, dasf_pkg::REG_BANK, bank);
            op = (i < 2) ? i : ($random(seed) & 15) % 10;
            {fil, acs, bn, pa} = $random(seed);
            fil[6] = 1'b0;
            opr = (i == 0) ? 8'h7f : (i == 1) ? 8'h00 : $random(seed);
            ea = acs ? {bank[3:0], fil} : {(fil >= 8'h80) ? 4'hf : 4'h0, fil};
            m = model(op, opr, acc, fl);
            fl = m[4:0];
            ex(op, 0, 0, opr, i[0]);
            chk(wb_addr, ea);
            chk({wb_data, wb_we}, {m[12:5], i[0]});
            chk(flags, {3'h0, fl});
            if (!i[0])
                chk(o_acc, m[12:5]);
        end
        m = model(dasf_pkg::ALU_ADD, {3'h0, fl}, acc, fl);
        ex(dasf_pkg::ALU_ADD, 1, dasf_pkg::STATUS_ADDR, 8'h5a, 1);
        chk({wb_we, flags}, {1'b0, 3'h0, m[4:0]});
        bus(1, dasf_pkg::REG_ACC, 8'hea);
        ex(dasf_pkg::ALU_STORE, 1, dasf_pkg::STATUS_ADDR, 8'h00, 1);
        chk(flags, 8'h0a);
        pa = 20'habcde;
        ex(dasf_pkg::ALU_JUMP, 0, 0, 8'h00, 0);
        chk({pc_ld, pc_t, flags}, {1'b1, 20'habcde, 8'h0a});
        // Pointer modes: post_increment_operand, pre_increment_operand, post_decrement_operand, offset, plain.
        be = 4'h3;
        bus(1, dasf_pkg::REG_PTR0, 32'h0ff);
        bus(1, dasf_pkg::REG_ACC, 8'hfe);
        for (int k = 0; k < 5; k++) begin
            fa = dasf_pkg::IND_BASE - ((k == 0) ? dasf_pkg::OFS_POST_INCREMENT_OPERAND
                                     : (k == 1) ? dasf_pkg::OFS_PRE_INCREMENT_OPERAND
                                     : (k == 2) ? dasf_pkg::OFS_POST_DECREMENT_OPERAND
                                     : (k == 3) ? dasf_pkg::OFS_OFFSET_BY_ACCUMULATOR_OPERAND : dasf_pkg::OFS_PLAIN);
            ex(dasf_pkg::ALU_STORE, 1, fa, 8'h00, 1);
            chk(wb_addr, (k == 0) ? 12'h0ff : (k == 3) ? 12'h0fe : 12'h100 + (k < 3));
            bus(0, dasf_pkg::REG_PTR0, 0);
            chk(q, (k == 1) ? 12'h101 : 12'h100);
            chk(flags, 8'h0a);
        end
        // Plain operand reached through the access bank still lands on the pointer.
        acs = 1'b0;
        fil = 8'hef;
        ex(dasf_pkg::ALU_STORE, 0, 0, 8'h00, 1);
        chk(wb_addr, 12'h100);
        lm = 1'b1;
        lit = 8'h33;
        ex(dasf_pkg::ALU_ADD, 0, 0, 8'h00, 1);
        chk(o_acc, 8'h31);
        // A second reset in mid-run clears every register.
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({o_acc, flags, wb_we, pc_ld}, 18'h0);
        bus(0, dasf_pkg::REG_PTR0, 0);
        chk(q, 0);
        test_done();
    end
endmodule
